// >>> rtl/floppy_port_pkg.sv
package floppy_port_pkg;

  // Cable and sensor inputs, all synchronised together
  localparam int SYNC_WIDTH = 12;
  localparam int SYN_SELECT = 0;
  localparam int SYN_MOTOR = 1;
  localparam int SYN_RESET = 2;
  localparam int SYN_STEP = 3;
  localparam int SYN_DIR = 4;
  localparam int SYN_SIDE = 5;
  localparam int SYN_WDATA = 6;
  localparam int SYN_WGATE = 7;
  localparam int SYN_INDEX = 8;
  localparam int SYN_PRESENT = 9;
  localparam int SYN_PROTECT = 10;
  localparam int SYN_SPEED = 11;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 12'hfff;

  // Head position
  localparam logic [6:0] TRACK_FIRST = 7'h00;
  localparam logic [6:0] TRACK_LAST = 7'h4f;
  localparam logic [6:0] TRACK_STEP = 7'h01;

  // Identification; the value is arbitrary
  localparam int ID_BITS = 32;
  localparam logic [ID_BITS-1:0] ID_VALUE = 32'h1e2d_3c4b;

  typedef enum logic [1:0] {
    ID_IDLE = 2'b00,
    ID_PRIMED = 2'b01,
    ID_SHIFT = 2'b10
  } id_state_t;

  // Motor line setup and hold kept by the host
  localparam int CLK_PERIOD_NS = 40;
  localparam int MOTOR_SETUP_NS = 1400;
  localparam int MOTOR_SETUP_CYCLES =
    (MOTOR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : floppy_port_pkg

// >>> rtl/flux_stream_if.sv
`timescale 1ns/100ps
interface flux_stream_if #(parameter int WIDTH = 1);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : flux_stream_if

// >>> rtl/flux_pair_buffer.sv
`timescale 1ns/100ps
module flux_pair_buffer #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  flux_stream_if.sink upstream,
  flux_stream_if.source downstream
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic head;
    logic [1:0] count;
  } buffer_state_t;

  buffer_state_t q;
  buffer_state_t next_q;
  logic push;
  logic pop;

  assign upstream.ready = (q.count != 2'h2);
  assign downstream.valid = (q.count != 2'h0);
  assign downstream.data = q.slot[q.head];
  assign push = upstream.valid && upstream.ready;
  assign pop = downstream.valid && downstream.ready;

  always_comb begin
    next_q = q;
    // Write slot uses the head before any pop, so a full cycle swap is safe
    if (push) begin
      next_q.slot[q.head ^ q.count[0]] = upstream.data;
    end
    if (pop) begin
      next_q.head = ~q.head;
    end
    case ({push, pop})
      2'b10: next_q.count = q.count + 2'h1;
      2'b01: next_q.count = q.count - 2'h1;
      default: next_q.count = q.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (reset)
    (q.count == 2'h2 && !pop) |=> (q.count == 2'h2 && !upstream.ready);
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer lost its fill while not drained");

  property p_order;
    @(posedge clk) disable iff (reset)
    (push && q.count == 2'h0 && !pop) |=> (downstream.data == $past(upstream.data));
  endproperty
  a_order: assert property (p_order)
    else $error("first word out is not first word in");

endmodule : flux_pair_buffer

// >>> rtl/external_drive_port.sv
// How it works
// - Drive answers status and control only while its own select is low; side choice and drive reset act at any time
// - Track-zero line pulled low while selected and head on track 00
// - Ready shows disk spinning at speed when motor on, else ID bits
// - Write-protect line pulled low while selected with protected disk
// - Revolution line pulses low once per spindle turn while selected
// - Each step moves head one track, none past 00 or 79; low direction inward, high outward
// - Selected drive puts read data out; unselected drives stay off
// - Write data recorded only while selected and write gate low
// - Change latch set at power-on or no disk; step clears it
// - Motor latch captures motor line on falling edge of own select
// - During drive reset the motor latch clears and writing is inhibited
// - Motor on then off then one select pulse loads ID shift register
// - Each of 32 select pulses presents one ID bit, MSB first
// - Drive reports only its one assigned identification value
`timescale 1ns/100ps
module external_drive_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic per_drive_select_n,
  input wire logic shared_motor_on_n,
  input wire logic drive_reset_n,
  input wire logic head_step_pulse_n,
  input wire logic step_direction,
  input wire logic head_surface_choice_n,
  input wire logic write_flux_data_n,
  input wire logic write_gate_n,
  input wire logic spindle_index,
  input wire logic disk_present,
  input wire logic disk_protected,
  input wire logic spindle_at_speed,
  input wire logic flux_bit,
  input wire logic flux_valid,
  output logic flux_ready,
  output logic head_at_outer_track_n_out,
  output logic head_at_outer_track_n_oe,
  output logic drive_ready_n_out,
  output logic drive_ready_n_oe,
  output logic media_protect_status_n_out,
  output logic media_protect_status_n_oe,
  output logic revolution_index_n_out,
  output logic revolution_index_n_oe,
  output logic read_flux_data_n_out,
  output logic read_flux_data_n_oe,
  output logic media_changed_n_out,
  output logic media_changed_n_oe,
  output logic motor_on,
  output logic [6:0] head_track,
  output logic head_side_one,
  output logic write_enable,
  output logic write_bit
);

  typedef struct packed {
    logic [floppy_port_pkg::SYNC_WIDTH-1:0] sync1;
    logic [floppy_port_pkg::SYNC_WIDTH-1:0] sync2;
    logic sel_prev;
    logic step_prev;
    logic motor_on;
    logic changed;
    logic [6:0] track;
    floppy_port_pkg::id_state_t id_state;
    logic [floppy_port_pkg::ID_BITS-1:0] id_shift;
    logic track0_oe;
    logic ready_oe;
    logic protect_oe;
    logic index_oe;
    logic read_oe;
    logic change_oe;
    logic write_enable;
    logic write_bit;
    logic side_one;
  } port_state_t;

  localparam port_state_t RESET_STATE = '{
    sync1: floppy_port_pkg::SYNC_RESET,
    sync2: floppy_port_pkg::SYNC_RESET,
    sel_prev: 1'b0,
    step_prev: 1'b1,
    motor_on: 1'b0,
    changed: 1'b1,
    track: floppy_port_pkg::TRACK_FIRST,
    id_state: floppy_port_pkg::ID_IDLE,
    id_shift: floppy_port_pkg::ID_VALUE,
    track0_oe: 1'b0,
    ready_oe: 1'b0,
    protect_oe: 1'b0,
    index_oe: 1'b0,
    read_oe: 1'b0,
    change_oe: 1'b0,
    write_enable: 1'b0,
    write_bit: 1'b0,
    side_one: 1'b0
  };

  port_state_t q;
  port_state_t next_q;

  // Decoded synchronised levels
  logic sel;
  logic sel_fall;
  logic rst;
  logic motor_low;
  logic step_fall;
  logic dir_out;
  logic present;
  logic protect;
  logic at_speed;
  logic index_on;
  logic gate_on;

  assign sel = !q.sync2[floppy_port_pkg::SYN_SELECT];
  assign sel_fall = sel && !q.sel_prev;
  assign rst = !q.sync2[floppy_port_pkg::SYN_RESET];
  assign motor_low = !q.sync2[floppy_port_pkg::SYN_MOTOR];
  assign step_fall = !q.sync2[floppy_port_pkg::SYN_STEP] && q.step_prev;
  assign dir_out = q.sync2[floppy_port_pkg::SYN_DIR];
  assign present = q.sync2[floppy_port_pkg::SYN_PRESENT];
  assign protect = q.sync2[floppy_port_pkg::SYN_PROTECT];
  assign at_speed = q.sync2[floppy_port_pkg::SYN_SPEED];
  assign index_on = q.sync2[floppy_port_pkg::SYN_INDEX];
  assign gate_on = !q.sync2[floppy_port_pkg::SYN_WGATE];

  // Read flux path; the buffer drains only while selected, so the head electronics stall once both words wait unselected
  flux_stream_if #(.WIDTH(1)) flux_in ();
  flux_stream_if #(.WIDTH(1)) flux_out ();

  assign flux_in.valid = flux_valid;
  assign flux_in.data = flux_bit;
  assign flux_ready = flux_in.ready;
  assign flux_out.ready = sel;

  flux_pair_buffer #(.WIDTH(1)) read_buffer (
    .clk(clk),
    .reset(reset),
    .upstream(flux_in),
    .downstream(flux_out)
  );

  always_comb begin
    next_q = q;
    next_q.sync1[floppy_port_pkg::SYN_SELECT] = per_drive_select_n;
    next_q.sync1[floppy_port_pkg::SYN_MOTOR] = shared_motor_on_n;
    next_q.sync1[floppy_port_pkg::SYN_RESET] = drive_reset_n;
    next_q.sync1[floppy_port_pkg::SYN_STEP] = head_step_pulse_n;
    next_q.sync1[floppy_port_pkg::SYN_DIR] = step_direction;
    next_q.sync1[floppy_port_pkg::SYN_SIDE] = head_surface_choice_n;
    next_q.sync1[floppy_port_pkg::SYN_WDATA] = write_flux_data_n;
    next_q.sync1[floppy_port_pkg::SYN_WGATE] = write_gate_n;
    next_q.sync1[floppy_port_pkg::SYN_INDEX] = spindle_index;
    next_q.sync1[floppy_port_pkg::SYN_PRESENT] = disk_present;
    next_q.sync1[floppy_port_pkg::SYN_PROTECT] = disk_protected;
    next_q.sync1[floppy_port_pkg::SYN_SPEED] = spindle_at_speed;
    next_q.sync2 = q.sync1;
    next_q.sel_prev = sel;
    next_q.step_prev = q.sync2[floppy_port_pkg::SYN_STEP];

    if (rst) begin
      next_q.motor_on = 1'b0;
    end else if (sel_fall) begin
      next_q.motor_on = motor_low;
    end

    if (step_fall && sel) begin
      if (!dir_out && q.track != floppy_port_pkg::TRACK_LAST) begin
        next_q.track = q.track + floppy_port_pkg::TRACK_STEP;
      end else if (dir_out && q.track != floppy_port_pkg::TRACK_FIRST) begin
        next_q.track = q.track - floppy_port_pkg::TRACK_STEP;
      end
    end

    // step clears, no disk sets; set wins
    if (step_fall && sel && present) begin
      next_q.changed = 1'b0;
    end
    if (!present) begin
      next_q.changed = 1'b1;
    end

    // Identification sequence follows the select edges; drive reset returns it to idle
    if (rst) begin
      next_q.id_state = floppy_port_pkg::ID_IDLE;
    end else if (sel_fall) begin
      if (q.motor_on && !motor_low) begin
        next_q.id_shift = floppy_port_pkg::ID_VALUE;
        next_q.id_state = floppy_port_pkg::ID_PRIMED;
      end else if (!q.motor_on && !motor_low) begin
        case (q.id_state)
          floppy_port_pkg::ID_PRIMED: begin
            next_q.id_state = floppy_port_pkg::ID_SHIFT;
          end
          floppy_port_pkg::ID_SHIFT: begin
            next_q.id_shift = {q.id_shift[floppy_port_pkg::ID_BITS-2:0],
                               1'b1};
          end
          default: begin
            next_q.id_state = floppy_port_pkg::ID_IDLE;
          end
        endcase
      end else begin
        next_q.id_state = floppy_port_pkg::ID_IDLE;
      end
    end

    next_q.track0_oe = sel && (q.track == floppy_port_pkg::TRACK_FIRST);
    next_q.ready_oe = sel && (q.motor_on ? (present && at_speed)
                                         : !q.id_shift[floppy_port_pkg::ID_BITS-1]);
    next_q.protect_oe = sel && protect;
    next_q.index_oe = sel && index_on;
    next_q.read_oe = sel && flux_out.valid && flux_out.data[0];
    next_q.change_oe = sel && q.changed;

    // reset inhibits writing
    // A protected disk is never written, whatever the host asks
    next_q.write_enable = sel && gate_on && !rst && !protect;
    next_q.write_bit = sel && gate_on && !rst && !protect &&
                       !q.sync2[floppy_port_pkg::SYN_WDATA];
    next_q.side_one = !q.sync2[floppy_port_pkg::SYN_SIDE];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // Open-drain lines only ever pull low
  assign head_at_outer_track_n_out = 1'b0;
  assign head_at_outer_track_n_oe = q.track0_oe;
  assign drive_ready_n_out = 1'b0;
  assign drive_ready_n_oe = q.ready_oe;
  assign media_protect_status_n_out = 1'b0;
  assign media_protect_status_n_oe = q.protect_oe;
  assign revolution_index_n_out = 1'b0;
  assign revolution_index_n_oe = q.index_oe;
  assign read_flux_data_n_out = 1'b0;
  assign read_flux_data_n_oe = q.read_oe;
  assign media_changed_n_out = 1'b0;
  assign media_changed_n_oe = q.change_oe;
  assign motor_on = q.motor_on;
  assign head_track = q.track;
  assign head_side_one = q.side_one;
  assign write_enable = q.write_enable;
  assign write_bit = q.write_bit;

  property p_unselected_quiet;
    @(posedge clk) disable iff (reset)
    !sel |=> (!q.track0_oe && !q.ready_oe && !q.read_oe && !q.change_oe);
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet)
    else $error("unselected drive pulls a status line");

  property p_track_zero;
    @(posedge clk) disable iff (reset)
    (sel && q.track == floppy_port_pkg::TRACK_FIRST) |=> q.track0_oe;
  endproperty
  a_track_zero: assert property (p_track_zero)
    else $error("track zero not shown");

  property p_ready_spin;
    @(posedge clk) disable iff (reset)
    (sel && q.motor_on) |=> (q.ready_oe == ($past(present) && $past(at_speed)));
  endproperty
  a_ready_spin: assert property (p_ready_spin)
    else $error("ready line does not follow spin state");

  property p_protect;
    @(posedge clk) disable iff (reset)
    (sel && protect) |=> (q.protect_oe && !q.write_enable);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected disk not reported");

  property p_index;
    @(posedge clk) disable iff (reset)
    (sel && index_on) |=> q.index_oe;
  endproperty
  a_index: assert property (p_index)
    else $error("revolution pulse missing");

  property p_step_in;
    @(posedge clk) disable iff (reset)
    (step_fall && sel && !dir_out && q.track != floppy_port_pkg::TRACK_LAST)
      |=> (q.track == $past(q.track) + floppy_port_pkg::TRACK_STEP);
  endproperty
  a_step_in: assert property (p_step_in)
    else $error("inward step did not add one track");

  property p_write_gate;
    @(posedge clk) disable iff (reset)
    q.write_enable |-> ($past(sel) && $past(gate_on) && !$past(rst));
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("writing without select and gate");

  property p_change_set;
    @(posedge clk) disable iff (reset)
    !present |=> q.changed ##1 (!$past(sel) || q.change_oe);
  endproperty
  a_change_set: assert property (p_change_set)
    else $error("change latch not set without disk");

  property p_motor_latch;
    @(posedge clk) disable iff (reset)
    (sel_fall && !rst) |=> (q.motor_on == $past(motor_low));
  endproperty
  a_motor_latch: assert property (p_motor_latch)
    else $error("motor latch missed select edge");

  property p_reset_stop;
    @(posedge clk) disable iff (reset)
    rst |=> (!q.motor_on && !q.write_enable);
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("motor or write alive in drive reset");

  property p_id_load;
    @(posedge clk) disable iff (reset)
    (sel_fall && !rst && q.motor_on && !motor_low) |=>
      (q.id_shift == floppy_port_pkg::ID_VALUE &&
       q.id_state == floppy_port_pkg::ID_PRIMED);
  endproperty
  a_id_load: assert property (p_id_load)
    else $error("ID register not loaded on motor off");

  property p_id_shift;
    @(posedge clk) disable iff (reset)
    (sel_fall && !rst && !q.motor_on && !motor_low &&
     q.id_state == floppy_port_pkg::ID_SHIFT) |=>
      (q.id_shift == {$past(q.id_shift[30:0]), 1'b1});
  endproperty
  a_id_shift: assert property (p_id_shift)
    else $error("ID register did not shift");

endmodule : external_drive_port

// >>> verif/floppy_host_model.sv
`timescale 1ns/100ps
module floppy_host_model (
  input wire logic clk,
  input wire logic ready_line_n,
  output logic select_n,
  output logic motor_n,
  output logic drive_reset_n,
  output logic step_n,
  output logic direction,
  output logic side_n,
  output logic wdata_n,
  output logic wgate_n
);
  localparam int SETUP = floppy_port_pkg::MOTOR_SETUP_CYCLES;

  initial begin
    select_n = 1'b1;
    motor_n = 1'b1;
    drive_reset_n = 1'b1;
    step_n = 1'b1;
    direction = 1'b0;
    side_n = 1'b1;
    wdata_n = 1'b1;
    wgate_n = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap

  task automatic set_cable(input logic s, input logic sd, input logic g,
                           input logic w);
    @(negedge clk);
    select_n = s;
    side_n = sd;
    wgate_n = g;
    wdata_n = w;
  endtask : set_cable

  task automatic switch_motor(input logic on);
    @(negedge clk);
    select_n = 1'b1;
    gap(SETUP);
    motor_n = !on;
    gap(SETUP);
    select_n = 1'b0;
    gap(SETUP);
  endtask : switch_motor

  task automatic step(input logic outward);
    @(negedge clk);
    direction = outward;
    gap(2);
    step_n = 1'b0;
    gap(4);
    step_n = 1'b1;
    gap(6);
  endtask : step

  // reset held for a chosen time
  task automatic hold_reset(input int n);
    @(negedge clk);
    drive_reset_n = 1'b0;
    gap(n);
  endtask : hold_reset

  task automatic release_reset();
    @(negedge clk);
    drive_reset_n = 1'b1;
  endtask : release_reset

  task automatic read_id(output logic [31:0] id);
    id = 32'h0000_0000;
    switch_motor(1'b1);
    switch_motor(1'b0);
    @(negedge clk);
    select_n = 1'b1;
    gap(3);
    repeat (32) begin
      select_n = 1'b0;
      gap(6);
      id = {id[30:0], ready_line_n};
      select_n = 1'b1;
      gap(3);
    end
  endtask : read_id
endmodule : floppy_host_model

// >>> verif/external_floppy_drive_port_tb_top.sv
`timescale 1ns/100ps
module external_floppy_drive_port_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sel_n, mot_n, dres_n, stp_n, dir, side_n, wd_n, wg_n;
  logic index, present, prot, speed, fbit, fvalid;
  logic [4:0] pin_lvl;
  logic fready, tk_oe, rdy_out, rdy_oe, wp_oe, idx_oe, rd_oe, chg_oe;
  logic motor_on, side_one, we, wb;
  logic [6:0] track;
  logic [31:0] id;
  int n_errors = 0;
  int num_checks = 0;
  int ones;
  // Pull-up on the ready line when nobody pulls it low
  wire logic ready_line_n = rdy_oe ? rdy_out : 1'b1;
  // Inputs side,sel,present,protect,speed,index,gate,wdata and expected outputs per row
  localparam logic [15:0] ROWS [5] = '{16'h284f, 16'hb431, 16'h2f59,
                                       16'ha90d, 16'hfc00};

  always #20 clk = ~clk;

  floppy_host_model floppy_host_model_inst (
    .clk(clk), .ready_line_n(ready_line_n), .select_n(sel_n),
    .motor_n(mot_n), .drive_reset_n(dres_n), .step_n(stp_n),
    .direction(dir), .side_n(side_n), .wdata_n(wd_n), .wgate_n(wg_n));

  external_drive_port external_drive_port_inst (
    .clk(clk), .reset(reset), .per_drive_select_n(sel_n),
    .shared_motor_on_n(mot_n), .drive_reset_n(dres_n),
    .head_step_pulse_n(stp_n), .step_direction(dir),
    .head_surface_choice_n(side_n), .write_flux_data_n(wd_n),
    .write_gate_n(wg_n), .spindle_index(index), .disk_present(present),
    .disk_protected(prot), .spindle_at_speed(speed), .flux_bit(fbit),
    .flux_valid(fvalid), .flux_ready(fready),
    .head_at_outer_track_n_out(pin_lvl[0]),
    .head_at_outer_track_n_oe(tk_oe),
    .drive_ready_n_out(rdy_out), .drive_ready_n_oe(rdy_oe),
    .media_protect_status_n_out(pin_lvl[1]),
    .media_protect_status_n_oe(wp_oe),
    .revolution_index_n_out(pin_lvl[2]), .revolution_index_n_oe(idx_oe),
    .read_flux_data_n_out(pin_lvl[3]), .read_flux_data_n_oe(rd_oe),
    .media_changed_n_out(pin_lvl[4]), .media_changed_n_oe(chg_oe),
    .motor_on(motor_on), .head_track(track), .head_side_one(side_one),
    .write_enable(we), .write_bit(wb));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Hold the word until the buffer takes it; a full buffer stalls here for up to 50 cycles, then the bench fails
  task automatic push_bit(input logic b);
    int k;
    @(negedge clk);
    fvalid = 1'b1;
    fbit = b;
    for (k = 0; k < 50 && fready !== 1'b1; k++) @(negedge clk);
    if (k == 50) begin
      check("flux ready wait", 32'h0, 32'h1);
      tally_and_finish();
    end else begin
      @(negedge clk);
      fvalid = 1'b0;
    end
  endtask : push_bit

  initial begin
    index = 1'b0;
    present = 1'b1;
    prot = 1'b0;
    speed = 1'b0;
    fbit = 1'b0;
    fvalid = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    floppy_host_model_inst.set_cable(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    check("motor after reset", 32'(motor_on), 32'h0);
    check("track after reset", 32'(track), 32'h0);
    check("change at power-on", 32'(chg_oe), 32'h1);
    check("track zero line", 32'(tk_oe), 32'h1);
    check("pull levels", 32'({pin_lvl, rdy_out}), 32'h0);
    $display("test reset done");

    floppy_host_model_inst.step(1'b0);
    check("track one", 32'(track), 32'h1);
    check("change cleared", 32'(chg_oe), 32'h0);
    check("off track zero", 32'(tk_oe), 32'h0);
    repeat (2) floppy_host_model_inst.step(1'b0);
    floppy_host_model_inst.step(1'b1);
    check("track two", 32'(track), 32'h2);
    // Last outward step at track zero must be refused
    repeat (3) floppy_host_model_inst.step(1'b1);
    check("track floor", 32'(track), 32'h0);
    present = 1'b0;
    floppy_host_model_inst.step(1'b0);
    check("change no disk", 32'(chg_oe), 32'h1);
    present = 1'b1;
    floppy_host_model_inst.step(1'b1);
    check("change re-cleared", 32'(chg_oe), 32'h0);
    $display("test step done");

    floppy_host_model_inst.switch_motor(1'b1);
    check("motor latched on", 32'(motor_on), 32'h1);
    $display("test motor done");

    foreach (ROWS[i]) begin
      floppy_host_model_inst.set_cable(ROWS[i][14], ROWS[i][15],
                                       ROWS[i][9], ROWS[i][8]);
      present = ROWS[i][13];
      prot = ROWS[i][12];
      speed = ROWS[i][11];
      index = ROWS[i][10];
      repeat (5) @(negedge clk);
      check("status row", 32'({side_one, wp_oe, idx_oe, rdy_oe, we, wb,
            tk_oe}), 32'(ROWS[i][6:0]));
    end
    $display("test rows done");
    // Last row leaves a protected disk, which would block the write check
    prot = 1'b0;
    index = 1'b0;

    floppy_host_model_inst.set_cable(1'b0, 1'b1, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    check("write before reset", 32'(we), 32'h1);
    floppy_host_model_inst.hold_reset(5);
    check("motor in reset", 32'(motor_on), 32'h0);
    check("write in reset", 32'(we), 32'h0);
    floppy_host_model_inst.release_reset();
    floppy_host_model_inst.set_cable(1'b1, 1'b1, 1'b1, 1'b1);
    $display("test drive reset done");

    floppy_host_model_inst.read_id(id);
    check("identification", id, floppy_port_pkg::ID_VALUE);
    $display("test id done");

    // Unselected drive must hold both words and refuse a third
    push_bit(1'b1);
    push_bit(1'b1);
    check("buffer full", 32'(fready), 32'h0);
    check("quiet unselected", 32'(rd_oe), 32'h0);
    ones = 0;
    floppy_host_model_inst.set_cable(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (12) begin
      @(negedge clk);
      ones += int'(rd_oe === 1'b1);
    end
    check("drained words", 32'(ones), 32'h2);
    check("buffer empty", 32'(fready), 32'h1);
    $display("test read stream done");
    tally_and_finish();
  end
endmodule : external_floppy_drive_port_tb_top
